/* rtl/ssfi_consts.svh */
// Operation
// - Host drives select, clock, input; device drives output.
// - Input bits captured on serial clock rising edge.
// - Output changes on serial clock falling edge.
// - Select falling edge starts a new command.
// - Works in clock idle low and high modes.
// - Output shows ready/busy during auto increment programming.
// - Write protect enables lock bit lockdown effect.
// - Pause suspends transfer, keeps command state.
// - Erase addresses decode sector and two blocks.
// - Pause changes take effect only at clock low.
// - Paused: output released, clock and input ignored.
// - Select rise while paused resets interface logic.
// - Status write refused if protect low and lock set.
`ifndef SSFI_CONSTS_SVH
`define SSFI_CONSTS_SVH
`define SSFI_CMD_READ      8'h03
`define SSFI_CMD_SER4K     8'h20
`define SSFI_CMD_BER32K    8'h52
`define SSFI_CMD_BER64K    8'hd8
`define SSFI_CMD_BPROG     8'h02
`define SSFI_CMD_AIP       8'had
`define SSFI_CMD_RDSR      8'h05
`define SSFI_CMD_WREN      8'h06
`define SSFI_CMD_WRDI      8'h04
`define SSFI_CMD_SWC       8'h01
`define SSFI_CMD_EBSY      8'h70
`define SSFI_CMD_DBSY      8'h80
`define SSFI_LOCK_BIT      7
`define SSFI_WEL_BIT       1
`define SSFI_AIP_BIT       6
`define SSFI_BUSY_BIT      0
`define SSFI_STATUS_RST    8'h1c
`define SSFI_STATUS_WMASK  8'hbc
`define SSFI_MASK_4K       24'hfff000
`define SSFI_MASK_32K      24'hff8000
`define SSFI_MASK_64K      24'hff0000
`define SSFI_FIFO_DEPTH    4
`endif

/* rtl/ssfi_pkg.sv */
package ssfi_pkg;
  typedef enum logic [2:0] {
    SSFI_IDLE = 3'b000,
    SSFI_CMD  = 3'b001,
    SSFI_ADDR = 3'b010,
    SSFI_DATA = 3'b011,
    SSFI_OUT  = 3'b100,
    SSFI_DONE = 3'b101
  } ssfi_state_t;
  typedef enum logic [1:0] {
    SSFI_ER_4K  = 2'b00,
    SSFI_ER_32K = 2'b01,
    SSFI_ER_64K = 2'b10
  } ssfi_erase_t;
  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  data;
  } ssfi_req_t;
endpackage : ssfi_pkg

/* rtl/ssfi_fifo.sv */
`timescale 1ns/100ps
module ssfi_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = cnt_reg < (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data  = mem_reg[rd_reg];
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (clk_en) begin
      if (push) begin
        mem_reg[wr_reg] <= in_data;
        wr_reg          <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ssfi_fifo

/* rtl/ssfi_device.sv */
`timescale 1ns/100ps
`include "ssfi_consts.svh"
module ssfi_device
  import ssfi_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        sel_n,
  input  wire logic        sclk,
  input  wire logic        sin,
  output logic             sout_o,
  output logic             sout_oe,
  input  wire logic        pause_n,
  input  wire logic        wprot_n,
  output ssfi_req_t        req_data,
  output logic             req_valid,
  input  wire logic        req_ready,
  output logic             req_overflow,
  input  wire logic [7:0]  rd_data,
  input  wire logic        write_busy,
  output logic [7:0]       status,
  output logic             paused,
  output logic             erase_valid,
  output ssfi_erase_t      erase_kind,
  output logic [23:0]      erase_base
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.
  logic [2:0] s1_reg;
  logic [2:0] s2_reg;
  logic       sclk_d_reg;
  logic       sel_d_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_reg     <= 3'h7;
      s2_reg     <= 3'h7;
      sclk_d_reg <= 1'b0;
      sel_d_reg  <= 1'b1;
    end else if (clk_en) begin
      s1_reg     <= {sel_n, sclk, pause_n};
      s2_reg     <= s1_reg;
      sclk_d_reg <= s2_reg[1];
      sel_d_reg  <= s2_reg[2];
    end
  end
  logic sin_s1_reg;
  logic sin_s2_reg;
  logic wp_s1_reg;
  logic wp_s2_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sin_s1_reg <= 1'b0;
      sin_s2_reg <= 1'b0;
      wp_s1_reg  <= 1'b1;
      wp_s2_reg  <= 1'b1;
    end else if (clk_en) begin
      sin_s1_reg <= sin;
      sin_s2_reg <= sin_s1_reg;
      wp_s1_reg  <= wprot_n;
      wp_s2_reg  <= wp_s1_reg;
    end
  end
  wire sel_s   = s2_reg[2];
  wire sclk_s  = s2_reg[1];
  wire pause_s = s2_reg[0];
  // Edges are judged only from synchronised levels, so either idle level works.
  wire rise    = sclk_s && !sclk_d_reg;
  wire fall    = !sclk_s && sclk_d_reg;
  wire sel_on  = !sel_s && sel_d_reg;
  wire sel_off = sel_s && !sel_d_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Pause follows its pin only while the serial clock is low.
  logic pause_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pause_reg <= 1'b0;
    end else if (clk_en && !sclk_s) begin
      pause_reg <= !pause_s;
    end
  end
  assign paused = pause_reg;
  // Clock and input are seen only while selected and not paused.
  wire live    = !sel_s && !pause_reg;
  wire do_rise = live && rise;
  wire do_fall = live && fall;
  ////////////////////////////////////////////////////////////////////////////
  ssfi_state_t state_reg;
  ssfi_state_t state_next;
  logic [7:0]  op_reg;
  logic [23:0] addr_reg;
  logic [7:0]  shin_reg;
  logic [7:0]  shout_reg;
  logic [4:0]  bit_reg;
  logic [7:0]  stat_reg;
  logic        aip_reg;
  logic        sout_reg;
  wire  [7:0]  shin_next = {shin_reg[6:0], sin_s2_reg};
  wire         byte_end  = do_rise && (bit_reg[2:0] == 3'h7);
  wire         addr_end  = do_rise && (bit_reg == 5'h17);
  wire         lock_hit  = !wp_s2_reg && stat_reg[`SSFI_LOCK_BIT];
  wire         op_is_read = (op_reg == `SSFI_CMD_READ) || (op_reg == `SSFI_CMD_RDSR);
  wire         is_erase   = (op_reg == `SSFI_CMD_SER4K) || (op_reg == `SSFI_CMD_BER32K)
                         || (op_reg == `SSFI_CMD_BER64K);
  wire         fifo_ready;
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SSFI_IDLE: state_next = state_reg;
      SSFI_CMD: begin
        if (byte_end) begin
          if (shin_next == `SSFI_CMD_RDSR) begin
            state_next = SSFI_OUT;
          end else if (shin_next == `SSFI_CMD_SWC) begin
            state_next = SSFI_DATA;
          end else begin
            state_next = SSFI_ADDR;
          end
        end
      end
      SSFI_ADDR: begin
        if (addr_end) begin
          state_next = op_is_read ? SSFI_OUT : (is_erase ? SSFI_DONE : SSFI_DATA);
        end
      end
      SSFI_DATA: state_next = byte_end ? SSFI_DONE : state_reg;
      SSFI_OUT:  state_next = state_reg;
      SSFI_DONE: state_next = state_reg;
      default:   state_next = SSFI_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  // A rising select always clears the interface, paused or not.
  wire drop = sel_off;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= SSFI_IDLE;
      bit_reg   <= 5'h00;
      shin_reg  <= 8'h00;
      op_reg    <= 8'h00;
      addr_reg  <= 24'h000000;
    end else if (clk_en) begin
      if (drop) begin
        state_reg <= SSFI_IDLE;
        bit_reg   <= 5'h00;
      end else if (sel_on) begin
        state_reg <= SSFI_CMD;
        bit_reg   <= 5'h00;
      end else if (do_rise) begin
        shin_reg  <= shin_next;
        state_reg <= state_next;
        if (state_reg == SSFI_CMD && byte_end) begin
          op_reg  <= shin_next;
          bit_reg <= 5'h00;
          if (shin_next != `SSFI_CMD_AIP) begin
            state_reg <= state_next;
          end else if (aip_reg) begin
            state_reg <= SSFI_DATA;
          end
        end else if (state_reg == SSFI_ADDR) begin
          addr_reg <= {addr_reg[22:0], sin_s2_reg};
          bit_reg  <= addr_end ? 5'h00 : bit_reg + 5'h01;
        end else begin
          bit_reg <= bit_reg + 5'h01;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Command outcome decoding; requests leave through the FIFO.
  wire cmd_done  = do_rise && (state_reg == SSFI_CMD) && byte_end;
  wire data_done = do_rise && (state_reg == SSFI_DATA) && byte_end;
  wire er_done   = do_rise && (state_reg == SSFI_ADDR) && addr_end && is_erase;
  wire swc_ok    = data_done && op_reg == `SSFI_CMD_SWC && stat_reg[`SSFI_WEL_BIT] && !lock_hit;
  wire prog_push = data_done && op_reg != `SSFI_CMD_SWC && stat_reg[`SSFI_WEL_BIT];
  ssfi_req_t fifo_in;
  assign fifo_in = '{opcode: op_reg, addr: addr_reg, data: shin_next};
  ssfi_fifo #(
    .WIDTH($bits(ssfi_req_t)),
    .DEPTH(`SSFI_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .in_valid (prog_push),
    .in_ready (fifo_ready),
    .in_data  (fifo_in),
    .out_valid(req_valid),
    .out_ready(req_ready),
    .out_data (req_data)
  );
  // A full FIFO drops the byte; the flag lets the core see the loss.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_overflow <= 1'b0;
    end else if (clk_en) begin
      req_overflow <= prog_push && !fifo_ready;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stat_reg <= `SSFI_STATUS_RST;
      aip_reg  <= 1'b0;
    end else if (clk_en) begin
      if (cmd_done && shin_next == `SSFI_CMD_WREN) begin
        stat_reg[`SSFI_WEL_BIT] <= 1'b1;
      end else if (cmd_done && shin_next == `SSFI_CMD_WRDI) begin
        stat_reg[`SSFI_WEL_BIT] <= 1'b0;
        aip_reg                 <= 1'b0;
      end else if (data_done && op_reg == `SSFI_CMD_SWC) begin
        if (swc_ok) begin
          stat_reg <= (shin_next & `SSFI_STATUS_WMASK) | (stat_reg & ~`SSFI_STATUS_WMASK);
        end
        stat_reg[`SSFI_WEL_BIT] <= 1'b0;
      end else if (prog_push) begin
        aip_reg <= op_reg == `SSFI_CMD_AIP;
        if (op_reg != `SSFI_CMD_AIP) begin
          stat_reg[`SSFI_WEL_BIT] <= 1'b0;
        end
      end else if (er_done) begin
        stat_reg[`SSFI_WEL_BIT] <= 1'b0;
      end
    end
  end
  assign status = {stat_reg[7], aip_reg, stat_reg[5:1], write_busy};
  ////////////////////////////////////////////////////////////////////////////
  // Erase base is the address with its in-block offset cleared.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      erase_valid <= 1'b0;
      erase_kind  <= SSFI_ER_4K;
      erase_base  <= 24'h000000;
    end else if (clk_en) begin
      erase_valid <= er_done && stat_reg[`SSFI_WEL_BIT];
      if (er_done) begin
        if (op_reg == `SSFI_CMD_SER4K) begin
          erase_kind <= SSFI_ER_4K;
          erase_base <= {addr_reg[22:0], sin_s2_reg} & `SSFI_MASK_4K;
        end else if (op_reg == `SSFI_CMD_BER32K) begin
          erase_kind <= SSFI_ER_32K;
          erase_base <= {addr_reg[22:0], sin_s2_reg} & `SSFI_MASK_32K;
        end else begin
          erase_kind <= SSFI_ER_64K;
          erase_base <= {addr_reg[22:0], sin_s2_reg} & `SSFI_MASK_64K;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Output shifter loads on entry and shifts on each falling edge.
  // Entry straight from the opcode is a status read; op_reg still holds the old opcode there.
  wire [7:0] out_byte = ((state_reg == SSFI_ADDR)
                      || (state_reg == SSFI_OUT && op_reg == `SSFI_CMD_READ)) ? rd_data : status;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      shout_reg <= 8'h00;
      sout_reg  <= 1'b0;
    end else if (clk_en) begin
      if (do_rise && state_next == SSFI_OUT && state_reg != SSFI_OUT) begin
        shout_reg <= out_byte;
      end else if (do_rise && state_reg == SSFI_OUT && bit_reg[2:0] == 3'h7) begin
        shout_reg <= out_byte;
      end else if (do_fall && state_reg == SSFI_OUT) begin
        sout_reg  <= shout_reg[7];
        shout_reg <= {shout_reg[6:0], 1'b0};
      end
    end
  end
  // In auto increment mode, with select low and idle, the pin shows ready.
  wire show_rb = aip_reg && state_reg == SSFI_CMD && bit_reg == 5'h00;
  assign sout_o  = show_rb ? !write_busy : sout_reg;
  assign sout_oe = live && (state_reg == SSFI_OUT || show_rb);
endmodule : ssfi_device

/* verif/ssfi_chk.sv */
`timescale 1ns/100ps
module ssfi_chk
  import ssfi_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        sel_n,
  input wire logic        sclk,
  input wire logic        pause_n,
  input wire logic        wprot_n,
  input wire logic        sout_o,
  input wire logic        sout_oe,
  input wire logic        req_valid,
  input wire logic [7:0]  status,
  input wire logic        paused,
  input wire logic        erase_valid,
  input wire ssfi_erase_t erase_kind,
  input wire logic [23:0] erase_base
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rst_vals;
    $rose(rst_n) |-> !sout_oe && !paused && !req_valid && status[7:1] == 7'h0e;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
  property p_desel;
    sel_n [*6] |-> !sout_oe;
  endproperty
  a_desel: assert property (p_desel) else $error("output driven while deselected");
  property p_pause_rel;
    paused [*2] |-> !sout_oe;
  endproperty
  a_pause_rel: assert property (p_pause_rel) else $error("output driven while paused");
  property p_sout_fall;
    sout_oe && $past(sout_oe) && !status[6] && $changed(sout_o) |-> !$past(sclk, 3);
  endproperty
  a_sout_fall: assert property (p_sout_fall) else $error("output moved off a falling edge");
  property p_pause_in;
    (!pause_n && !sclk && !sel_n) [*6] |-> paused;
  endproperty
  a_pause_in: assert property (p_pause_in) else $error("pause not entered");
  property p_pause_out;
    (pause_n && !sclk) [*6] |-> !paused;
  endproperty
  a_pause_out: assert property (p_pause_out) else $error("pause not left");
  property p_lock;
    (!wprot_n && status[7]) [*4] |=> $stable({status[7], status[5:2]});
  endproperty
  a_lock: assert property (p_lock) else $error("locked status bits changed");
  property p_erase_align;
    erase_valid |-> (erase_kind == SSFI_ER_4K) ? erase_base[11:0] == 12'h000 :
      (erase_kind == SSFI_ER_32K) ? erase_base[14:0] == 15'h0000 :
      (erase_kind == SSFI_ER_64K && erase_base[15:0] == 16'h0000);
  endproperty
  a_erase_align: assert property (p_erase_align) else $error("erase base misaligned");
endmodule : ssfi_chk
////////////////////////////////////////////////////////////////////////////////
bind ssfi_device ssfi_chk ssfi_chk_i (.ref_clk, .rst_n, .sel_n, .sclk, .pause_n, .wprot_n,
  .sout_o, .sout_oe, .req_valid, .status, .paused, .erase_valid, .erase_kind, .erase_base);

/* verif/ssfi_host.sv */
`timescale 1ns/100ps
module ssfi_host (
  output logic     sel_n,
  output logic     sclk,
  output logic     sin,
  input wire logic sout_o
);
  logic idle_lvl = 1'b0;
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
    sin = 1'b0;
  end
  // The link clock moves outside frames only to take the next frame's idle level, 200 ns before select falls.
  task automatic start(input logic m3);
    idle_lvl = m3;
    sclk = m3;
    #200 sel_n = 1'b0;
    #200;
  endtask : start
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      sin = tx[i];
      #160 sclk = 1'b1;
      #160 rx[i] = sout_o; // Read late in the high phase, where the output has settled.
    end
  endtask : xbyte
  task automatic idle_clk(input int n);
    repeat (n) begin
      sclk = 1'b0;
      sin = ~sin;
      #400 sclk = 1'b1;
      #160;
    end
  endtask : idle_clk
  task automatic stop;
    sclk = idle_lvl;
    #160 sel_n = 1'b1; // Select stays low until the last bit is through.
    sin = ~sin;
    #400;
  endtask : stop
endmodule : ssfi_host

/* verif/tb_spi_serial_flash_interface.sv */
`timescale 1ns/100ps
`include "ssfi_consts.svh"
module tb_spi_serial_flash_interface
  import ssfi_pkg::*;
;
  logic        ref_clk, rst_n, pause_n, wprot_n, req_ready, sel_n, sclk, sin, write_busy;
  logic        sout_o, sout_oe, req_valid, req_overflow, paused, erase_valid;
  logic [7:0]  rd_data, status, rx, d;
  logic [23:0] erase_base, a;
  ssfi_req_t   req_data;
  ssfi_erase_t erase_kind;
  logic [39:0] eq [$];
  logic [39:0] rq [$];
  logic [23:0] msk [3] = '{`SSFI_MASK_4K, `SSFI_MASK_32K, `SSFI_MASK_64K};
  logic [7:0]  ops [3] = '{`SSFI_CMD_SER4K, `SSFI_CMD_BER32K, `SSFI_CMD_BER64K};
  int          n_errors = 0;
  int          n_tests = 0;
  int          n_ovf = 0;
  ssfi_device ssfi_device_i (
    .ref_clk, .rst_n, .clk_en(1'b1), .sel_n, .sclk, .sin, .sout_o, .sout_oe, .pause_n,
    .wprot_n, .req_data, .req_valid, .req_ready, .req_overflow, .rd_data,
    .write_busy, .status, .paused, .erase_valid, .erase_kind, .erase_base
  );
  ssfi_host ssfi_host_i (.sel_n, .sclk, .sin, .sout_o(sout_oe ? sout_o : ~sout_o));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk_word(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask : chk_word
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_word({32'h0, got}, {32'h0, exp});
  endtask : chk_byte
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick
  // Whole frame; tail holds n bytes after the opcode, most significant one sent first.
  task automatic cmd(input logic m3, input logic [7:0] op, input logic [31:0] tail, input int n);
    ssfi_host_i.start(m3);
    ssfi_host_i.xbyte(op, rx);
    for (int i = n - 1; i >= 0; i--) ssfi_host_i.xbyte(tail[8*i +: 8], rx);
    ssfi_host_i.stop();
  endtask : cmd
  task automatic stw(input logic [7:0] v, input logic [7:0] e, input logic wp);
    tick(1);
    wprot_n = wp;
    cmd(1'b0, `SSFI_CMD_WREN, 32'h0, 0);
    cmd(1'b1, `SSFI_CMD_SWC, {24'h0, v}, 1);
    cmd(1'b0, `SSFI_CMD_RDSR, 32'h0, 1);
    chk_byte(rx & `SSFI_STATUS_WMASK, e);
  endtask : stw
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // Results are matched against the oldest expectation as they appear.
  always @(posedge ref_clk) begin
    if (erase_valid) chk_word({14'h0, erase_kind, erase_base}, eq.pop_front());
    if (req_valid && req_ready) chk_word(req_data, rq.pop_front());
    if (req_overflow) n_ovf++;
  end
  initial begin
    rst_n = 1'b0;
    pause_n = 1'b1;
    wprot_n = 1'b1;
    req_ready = 1'b0;
    rd_data = 8'h00;
    write_busy = 1'b0;
    void'($urandom(32'h8511));
    tick(2);
    rst_n = 1'b1;
    tick(4);
    cmd(1'b0, `SSFI_CMD_RDSR, 32'h0, 1);
    chk_byte(rx, `SSFI_STATUS_RST);
    $display("test reset done");
    for (int k = 0; k < 3; k++) begin
      a = 24'($urandom);
      eq.push_back({14'h0, k[1:0], a & msk[k]});
      cmd(k[0], `SSFI_CMD_WREN, 32'h0, 0);
      cmd(k[0], ops[k], {8'h0, a}, 3);
    end
    $display("test erase done");
    tick(1);
    rd_data = 8'($urandom);
    cmd(1'b1, `SSFI_CMD_READ, {24'($urandom), 8'h00}, 4);
    chk_byte(rx, rd_data);
    cmd(1'b0, `SSFI_CMD_RDSR, 32'h0, 1);
    chk_byte(rx, `SSFI_STATUS_RST);
    $display("test read done");
    for (int i = 0; i < 5; i++) begin
      a = 24'($urandom);
      d = 8'($urandom);
      if (i < 4) rq.push_back({`SSFI_CMD_BPROG, a, d});
      cmd(1'b0, `SSFI_CMD_WREN, 32'h0, 0);
      cmd(i[0], `SSFI_CMD_BPROG, {a, d}, 4);
    end
    chk_word(40'(n_ovf), 40'h1);
    req_ready = 1'b1;
    tick(20);
    chk_byte({7'h0, req_valid}, 8'h00);
    $display("test buffer done");
    stw(8'h80, 8'h80, 1'b1);
    stw(8'h3c, 8'h80, 1'b0);
    stw(8'h00, 8'h00, 1'b1);
    stw(8'h0c, 8'h0c, 1'b0);
    $display("test protect done");
    a = 24'($urandom);
    eq.push_back({14'h0, 2'h0, a & `SSFI_MASK_4K});
    cmd(1'b0, `SSFI_CMD_WREN, 32'h0, 0);
    ssfi_host_i.start(1'b0);
    ssfi_host_i.xbyte(`SSFI_CMD_SER4K, rx);
    ssfi_host_i.xbyte(a[23:16], rx);
    tick(1);
    pause_n = 1'b0;
    tick(6);
    chk_byte({7'h0, paused}, 8'h00);
    ssfi_host_i.idle_clk(3);
    chk_byte({7'h0, paused}, 8'h01);
    tick(1);
    pause_n = 1'b1;
    tick(6);
    chk_byte({7'h0, paused}, 8'h01);
    ssfi_host_i.xbyte(a[15:8], rx);
    ssfi_host_i.xbyte(a[7:0], rx);
    ssfi_host_i.stop();
    tick(10);
    chk_word(40'(eq.size() + rq.size()), 40'h0);
    $display("test pause done");
    a = 24'($urandom);
    d = 8'($urandom);
    rq.push_back({`SSFI_CMD_AIP, a, d});
    rq.push_back({`SSFI_CMD_AIP, a, ~d});
    cmd(1'b0, `SSFI_CMD_WREN, 32'h0, 0);
    cmd(1'b1, `SSFI_CMD_AIP, {a, d}, 4);
    write_busy = 1'b1;
    ssfi_host_i.start(1'b0);
    chk_byte({sout_oe, sout_o, status[6], status[0], 4'h0}, 8'hb0);
    write_busy = 1'b0;
    tick(1);
    chk_byte({sout_oe, sout_o, status[6], status[0], 4'h0}, 8'he0);
    ssfi_host_i.xbyte(`SSFI_CMD_AIP, rx);
    ssfi_host_i.xbyte(~d, rx);
    ssfi_host_i.stop();
    cmd(1'b0, `SSFI_CMD_WRDI, 32'h0, 0);
    chk_byte(status & 8'h43, 8'h00);
    chk_word(40'(rq.size()), 40'h0);
    $display("test auto increment done");
    summarize();
  end
  initial begin
    #1000000;
    n_errors++;
    summarize();
  end
endmodule : tb_spi_serial_flash_interface
